// >>> rtl/bt_defs.svh
// Constants for the board test-mode logic: pin counts, qualifier pattern, mode bit.
// Assumes it is included by bare name from the package and design modules.
// Contract
// [R1] Offer NAND tree, drive-high, drive-low tests.
// [R2] Tester holds two qualifier pins high.
// [R3] Tester holds six qualifier pins low.
// [R4] Strobe rise with pattern enters test mode.
// [R5] Latch qualifier levels at every strobe rise.
// [R6] Wrong latched pattern keeps normal operation.
// [R7] Strobe held high selects NAND tree.
// [R8] Inputs and bidirectionals chained, one stage each.
// [R9] Chain from start pin, ordered, one output.
// [R10] Strobe held low selects drive test.
// [R11] Mode pin swaps odd/even drive levels.
// [R12] Each stage NANDs previous output with pin.
`ifndef BT_DEFS_SVH
`define BT_DEFS_SVH
// Number of chained pins, index 0 is the chain start pin
`define BT_CHAIN_LEN   130
// Driven pin groups in the drive test
`define BT_EVEN_LEN    73
`define BT_ODD_LEN     66
// Qualifier pins: bits 1:0 must be high, bits 7:2 low
`define BT_QUAL_LEN    8
`define BT_QUAL_REQ    8'h03
// Qualifier bit that doubles as the drive pattern select
`define BT_MODE_BIT    0
// Reset values
`define BT_QUAL_RST    8'h00
`endif

// >>> rtl/bt_pkg.sv
// Types shared by the board test-mode modules.
// Assumes bt_defs.svh is on the include path.
`include "bt_defs.svh"
package bt_pkg;
    typedef logic [`BT_CHAIN_LEN-1:0] chain_vec_t;   // Chained pin levels
    typedef logic [`BT_QUAL_LEN-1:0]  qual_vec_t;    // Qualifier pin levels
    // Test function currently selected
    typedef enum logic [1:0] {
        FN_NORMAL = 2'b00,
        FN_NAND   = 2'b01,
        FN_DRIVE  = 2'b10
    } test_fn_t;
endpackage : bt_pkg

// >>> rtl/bt_chain_if.sv
// Carrier between the test-mode top and its NAND chain.
// Assumes both ends share the clock of the top.
interface bt_chain_if;
    import bt_pkg::*;
    chain_vec_t bits;     // Synchronised chained pin levels
    logic       result;   // Chain output, combinational
    modport src   (output bits, input result);
    modport chain (input bits, output result);
endinterface : bt_chain_if

// >>> rtl/bt_nand_chain.sv
// Combinational NAND tree across all chained pins, start pin first.
// Assumes its inputs are already synchronised; the caller registers the result.
`include "bt_defs.svh"
module bt_nand_chain
    import bt_pkg::*;
(
    // Chain link
    bt_chain_if.chain link
);
    logic [`BT_CHAIN_LEN:0] stage;   // Stage outputs, stage[0] is the seed

    // Seed high so the first stage simply inverts the start pin
    assign stage[0] = 1'b1;

    // One stage per chained pin, in table order [R8] [R9]
    genvar k;
    generate
        for (k = 0; k < `BT_CHAIN_LEN; k++) begin : g_stage
            // Previous output NAND this pin; with all others high, toggling an even-index pin flips the end [R12]
            assign stage[k+1] = ~(stage[k] & link.bits[k]);
        end
    endgenerate

    // Final stage is the chain output pin level [R9]
    assign link.result = stage[`BT_CHAIN_LEN];
endmodule : bt_nand_chain

// >>> rtl/bt_test_top.sv
// Board test-mode logic: entry on strobe rise, NAND tree and drive tests.
// Assumes all pin inputs are asynchronous to clk and the pad ring applies the enables.
`include "bt_defs.svh"

module bt_test_top
    import bt_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Tester pins
    input  wire logic                    strobe_pin,
    input  wire logic [`BT_QUAL_LEN-1:0] qual_pins,
    input  wire logic [`BT_CHAIN_LEN-1:0] chain_pins,
    // Test mode status to the pad ring
    output logic                         test_active,
    output logic                         bidir_in_force,
    // NAND tree output pin
    output logic                         chain_out,
    output logic                         chain_oe,
    // Drive test pins
    output logic [`BT_EVEN_LEN-1:0]      drive_even,
    output logic [`BT_ODD_LEN-1:0]       drive_odd,
    output logic                         drive_oe
);
    // All state of the block in one record
    typedef struct packed {
        logic       strb_s1;      // Strobe sync, first stage
        logic       strb_s2;      // Strobe sync, second stage
        logic       strb_d;       // Delayed strobe for edge detect
        qual_vec_t  qual_s1;      // Qualifier sync, first stage
        qual_vec_t  qual_s2;      // Qualifier sync, second stage
        chain_vec_t chain_s1;     // Chain sync, first stage
        chain_vec_t chain_s2;     // Chain sync, second stage
        qual_vec_t  qual_lat;     // Pattern caught at the last strobe rise
        logic       test;         // Test mode entered
        test_fn_t   fn;           // Selected test function
        logic       chain_o;      // Registered chain result
        logic       mode_sel;     // Registered drive pattern select
    } state_t;

    state_t st_r;                 // Current state
    state_t st_nxt;               // Next state

    logic   strobe_rise;          // Synchronised strobe went 0 to 1
    logic   qual_match;           // Sampled pattern equals the entry pattern

    // Link to the NAND chain
    bt_chain_if chain_link ();

    bt_nand_chain u_chain (
        .link (chain_link.chain)
    );

    // Only second-stage levels reach the chain
    assign chain_link.bits = st_r.chain_s2;

    // Edge seen after the synchroniser, never on the first stage
    assign strobe_rise = st_r.strb_s2 & ~st_r.strb_d;

    // Two pins high, six pins low is the only entry pattern [R2] [R3]
    assign qual_match  = (st_r.qual_s2 == `BT_QUAL_REQ);

    // Next-state logic
    always_comb begin
        st_nxt          = st_r;
        // Synchronisers shift every cycle
        st_nxt.strb_s1  = strobe_pin;
        st_nxt.strb_s2  = st_r.strb_s1;
        st_nxt.strb_d   = st_r.strb_s2;
        st_nxt.qual_s1  = qual_pins;
        st_nxt.qual_s2  = st_r.qual_s1;
        st_nxt.chain_s1 = chain_pins;
        st_nxt.chain_s2 = st_r.chain_s1;
        // Every rise re-latches the pattern and re-decides entry [R5]
        if (strobe_rise) begin
            st_nxt.qual_lat = st_r.qual_s2;
            // Match enters test mode [R4]; mismatch leaves normal operation [R6]
            st_nxt.test     = qual_match;
        end
        // Function follows the strobe level once in test mode [R1]
        if (!st_nxt.test) begin
            st_nxt.fn = FN_NORMAL;
        end else if (st_r.strb_s2) begin
            st_nxt.fn = FN_NAND;        // Strobe held high [R7]
        end else begin
            st_nxt.fn = FN_DRIVE;       // Strobe held low [R10]
        end
        // Chain result is registered so the pin does not glitch per stage
        st_nxt.chain_o  = chain_link.result;
        // Pattern select taken from the live mode pin after sync [R11]
        st_nxt.mode_sel = st_r.qual_s2[`BT_MODE_BIT];
    end

    // State register; reset loads constants only
    // Sync stages reset low; the strobe idles low, so no false rise follows reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '{strb_s1: 1'b0, strb_s2: 1'b0, strb_d: 1'b0,
                      qual_s1: `BT_QUAL_RST, qual_s2: `BT_QUAL_RST,
                      chain_s1: '0, chain_s2: '0,
                      qual_lat: `BT_QUAL_RST, test: 1'b0, fn: FN_NORMAL,
                      chain_o: 1'b0, mode_sel: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Status outputs straight from flops
    assign test_active    = st_r.test;
    // Bidirectional pins act as inputs while the chain runs [R8]
    assign bidir_in_force = (st_r.fn == FN_NAND);

    // Chain output pin driven only in NAND test [R9]
    assign chain_out = st_r.chain_o;
    assign chain_oe  = (st_r.fn == FN_NAND);

    // Select 0: odd low, even high; select 1 reverses it [R11]
    assign drive_even = {`BT_EVEN_LEN{~st_r.mode_sel}};
    assign drive_odd  = {`BT_ODD_LEN{st_r.mode_sel}};
    assign drive_oe   = (st_r.fn == FN_DRIVE);

    // A strobe rise seen with the entry pattern present
    sequence s_rise_match;
        strobe_rise && qual_match;
    endsequence

    // A strobe rise seen with any other pattern
    sequence s_rise_miss;
        strobe_rise && !qual_match;
    endsequence

    // Entry then strobe still high: NAND selected one cycle later
    sequence s_enter_high;
        s_rise_match ##1 st_r.strb_s2;
    endsequence

    // Test mode running with the strobe settled high and no new rise
    sequence s_held_high;
        test_active && st_r.strb_s2 && !strobe_rise;
    endsequence

    // Properties below watch post-synchroniser state, so pin skew never enters them

    // Entry needs both the rise and the pattern in the same cycle
    AST_ENTRY: assert property (@(posedge clk) disable iff (reset) // [R4]
        s_rise_match |=> test_active)
        else $error("Matching pattern on strobe rise did not enter test mode");

    // A refused rise must leave every test driver off as well
    AST_NO_ENTRY: assert property (@(posedge clk) disable iff (reset) // [R6]
        s_rise_miss |=> !test_active ##1 (!chain_oe && !drive_oe))
        else $error("Wrong pattern entered or kept test mode");

    // The latched copy is the pattern the entry decision was made on
    AST_LATCH: assert property (@(posedge clk) disable iff (reset) // [R5]
        strobe_rise |=> (st_r.qual_lat == $past(st_r.qual_s2)))
        else $error("Qualifier pattern not latched at strobe rise");

    // Latched pattern only moves on a strobe rise
    AST_LATCH_STABLE: assert property (@(posedge clk) disable iff (reset) // [R5]
        !strobe_rise |=> $stable(st_r.qual_lat))
        else $error("Latched qualifier pattern changed without a strobe rise");

    // Only a strobe rise may move test mode; reset is the other way out
    AST_HOLD: assert property (@(posedge clk) disable iff (reset) // [R5]
        !strobe_rise |=> $stable(test_active))
        else $error("Test mode changed without a strobe rise");

    // Entry with the strobe still high lands in the NAND tree
    AST_NAND_SEL: assert property (@(posedge clk) disable iff (reset) // [R7]
        s_enter_high |=> (chain_oe && bidir_in_force && !drive_oe))
        else $error("Strobe high in test mode did not select NAND tree");

    // Any settled high strobe keeps the chain selected, not only right after entry
    // Catches a function register that forgets the strobe level once set
    AST_NAND_HELD: assert property (@(posedge clk) disable iff (reset) // [R7]
        s_held_high |=> (chain_oe && bidir_in_force && !drive_oe))
        else $error("Strobe held high in test mode lost the NAND tree");

    // Low strobe in test mode hands the pins to the drive test
    AST_DRIVE_SEL: assert property (@(posedge clk) disable iff (reset) // [R10]
        (test_active && !st_r.strb_s2 && !strobe_rise) |=> (drive_oe && !chain_oe))
        else $error("Strobe low in test mode did not select drive test");

    // Mode select lags the synchronised pin by one register
    AST_DRIVE_PAT: assert property (@(posedge clk) disable iff (reset) // [R11]
        drive_oe |-> (drive_even[0] == !$past(st_r.qual_s2[`BT_MODE_BIT])
                      && drive_odd[0] == $past(st_r.qual_s2[`BT_MODE_BIT])
                      && drive_even[0] != drive_odd[0]))
        else $error("Drive pattern does not follow the mode pin");

    // Every pin of a drive group carries the same level
    AST_DRIVE_GROUPS: assert property (@(posedge clk) disable iff (reset) // [R11]
        drive_oe |-> ((drive_even == {`BT_EVEN_LEN{drive_even[0]}})
                      && (drive_odd == {`BT_ODD_LEN{drive_odd[0]}})))
        else $error("Drive group pins do not share one level");

    // All chained pins high: stages alternate from the high seed,
    // so an even-length chain ends high and an odd one low
    AST_CHAIN: assert property (@(posedge clk) disable iff (reset) // [R12]
        (&st_r.chain_s2) |=> (chain_out == ((`BT_CHAIN_LEN % 2) == 0)))
        else $error("Chain output wrong with every chained pin high");

    // Start pin alone toggling must reach the output pin
    AST_START_TOGGLE: assert property (@(posedge clk) disable iff (reset) // [R9]
        (chain_oe && (&st_r.chain_s2[`BT_CHAIN_LEN-1:1]) && $changed(st_r.chain_s2[0])
         && $stable(st_r.chain_s2[`BT_CHAIN_LEN-1:1])) |=> $changed(chain_out))
        else $error("Toggling the start pin did not toggle the chain output");

    // Outside test mode no test driver may reach a pin
    AST_NORMAL_QUIET: assert property (@(posedge clk) disable iff (reset) // [R1]
        !test_active |-> (!drive_oe && !chain_oe && !bidir_in_force))
        else $error("Test driver enabled outside test mode");

    // Entering test mode always picks one of the test functions
    AST_ACTIVE_FN: assert property (@(posedge clk) disable iff (reset) // [R1]
        $rose(test_active) |-> (chain_oe || drive_oe))
        else $error("Test mode entered with no test function selected");

    // Chain and drive tests must never fight over the pins
    AST_ONE_OE: assert property (@(posedge clk) disable iff (reset) // [R1]
        !(chain_oe && drive_oe))
        else $error("Chain and drive tests enabled together");

    // Bidirectional pins turn to inputs exactly while the chain drives its output
    AST_BIDIR_FORCE: assert property (@(posedge clk) disable iff (reset) // [R8]
        bidir_in_force == chain_oe)
        else $error("Bidirectional input force out of step with the NAND tree");
endmodule : bt_test_top

// >>> bench/bt_ate_model.sv
// Tester stand-in that drives the board test pins of the device.
// Assumes the bench clock paces it; every pin holds its level between calls.
`include "bt_defs.svh"
module bt_ate_model
    import bt_pkg::*;
(
    // Pacing clock
    input  wire logic clk,
    // Pins towards the device
    output logic       strobe_pin,
    output qual_vec_t  qual_pins,
    output chain_vec_t chain_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet pins at time zero
    initial begin
        strobe_pin = 1'b0;
        qual_pins  = `BT_QUAL_RST;
        chain_pins = '1;
    end
    // Pass n edges and land just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // Settle a pattern, then give the strobe a clean low-to-high edge
    task automatic strobe_rise(input qual_vec_t q);
        strobe_pin = 1'b0;
        qual_pins  = q;
        step(4);             // Pattern must beat the synchronisers
        strobe_pin = 1'b1;
        step(8);
    endtask : strobe_rise
    // Low strobe after entry asks for the drive test
    task automatic strobe_drop();
        strobe_pin = 1'b0;
        step(8);
    endtask : strobe_drop
    // Mode pin for the drive pattern
    task automatic set_mode(input logic m);
        qual_pins[`BT_MODE_BIT] = m;
        step(8);
    endtask : set_mode
    // New levels on every chained pin
    task automatic set_chain(input chain_vec_t v);
        chain_pins = v;
        step(8);
    endtask : set_chain
endmodule : bt_ate_model

// >>> bench/board_test_mode_nand_tree_tb_top.sv
// Self-checking bench for the board test-mode logic.
// Assumes the tester model owns all pin inputs; bench owns clock and reset.
`include "bt_defs.svh"
module board_test_mode_nand_tree_tb_top
    import bt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clk, reset, strobe_pin;   // Clock, reset, strobe
    qual_vec_t                qual_pins;                // Qualifier pins
    chain_vec_t               chain_pins;               // Chained pins
    logic                     test_active, bidir_in_force, chain_out, chain_oe, drive_oe;
    logic [`BT_EVEN_LEN-1:0]  drive_even;               // Even drive group
    logic [`BT_ODD_LEN-1:0]   drive_odd;                // Odd drive group
    int                       miscompares, samples_checked, cycles;
    bt_ate_model u_ate (.clk(clk), .strobe_pin(strobe_pin), .qual_pins(qual_pins), .chain_pins(chain_pins));
    bt_test_top u_dut (.clk(clk), .reset(reset), .strobe_pin(strobe_pin), .qual_pins(qual_pins),
        .chain_pins(chain_pins), .test_active(test_active), .bidir_in_force(bidir_in_force),
        .chain_out(chain_out), .chain_oe(chain_oe), .drive_even(drive_even), .drive_odd(drive_odd),
        .drive_oe(drive_oe));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Compare and count; wide enough for every output
    task automatic check(input string what, input logic [`BT_CHAIN_LEN-1:0] seen,
                         input logic [`BT_CHAIN_LEN-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Reference chain, seed one, start pin first
    function automatic logic chain_ref(input chain_vec_t v);
        logic s;
        s = 1'b1;
        for (int k = 0; k < `BT_CHAIN_LEN; k++) s = ~(s & v[k]);
        return s;
    endfunction : chain_ref
    // Every single wrong qualifier bit is refused
    task automatic scn_bad_pattern();
        for (int i = 0; i < `BT_QUAL_LEN; i++) begin
            u_ate.strobe_rise(`BT_QUAL_REQ ^ (8'h01 << i));
            check("test_active", test_active, 1'b0);
            check("chain_oe", chain_oe, 1'b0);
        end
    endtask : scn_bad_pattern
    // Entry with strobe held high, walking zero down the chain
    task automatic scn_nand();
        chain_vec_t v;
        u_ate.strobe_rise(`BT_QUAL_REQ);
        check("test_active", test_active, 1'b1);
        check("chain_oe", chain_oe, 1'b1);
        check("bidir_in_force", bidir_in_force, 1'b1);
        check("drive_oe", drive_oe, 1'b0);
        for (int k = 0; k < `BT_CHAIN_LEN; k++) begin
            v = '1;
            v[k] = 1'b0;
            u_ate.set_chain(v);
            check("chain_out", chain_out, chain_ref(v));
        end
        // Zeros piling up from the start pin toggle the output at every step
        v = '1;
        u_ate.set_chain(v);
        check("chain_out", chain_out, 1'b1);
        for (int k = 0; k < `BT_CHAIN_LEN; k++) begin
            v[k] = 1'b0;
            u_ate.set_chain(v);
            check("chain_out", chain_out, k[0] ? 1'b1 : 1'b0);
        end
    endtask : scn_nand
    // Strobe low selects the drive test; mode pin swaps groups
    task automatic scn_drive();
        u_ate.strobe_drop();
        check("drive_oe", drive_oe, 1'b1);
        check("chain_oe", chain_oe, 1'b0);
        check("bidir_in_force", bidir_in_force, 1'b0);
        for (int m = 0; m < 2; m++) begin
            u_ate.set_mode(m[0]);
            check("drive_even", drive_even, {`BT_EVEN_LEN{~m[0]}});
            check("drive_odd", drive_odd, {`BT_ODD_LEN{m[0]}});
        end
    endtask : scn_drive
    // A later rise with a wrong pattern drops test mode
    task automatic scn_exit();
        u_ate.strobe_rise(8'h00);
        check("test_active", test_active, 1'b0);
        check("drive_oe", drive_oe, 1'b0);
        check("chain_oe", chain_oe, 1'b0);
        check("bidir_in_force", bidir_in_force, 1'b0);
    endtask : scn_exit
    // Reset in the middle of a drive test drops straight back to normal
    task automatic scn_reset();
        u_ate.strobe_rise(`BT_QUAL_REQ);
        u_ate.strobe_drop();
        check("drive_oe", drive_oe, 1'b1);
        reset = 1'b1;
        u_ate.step(2);
        check("test_active", test_active, 1'b0);
        check("drive_oe", drive_oe, 1'b0);
        reset = 1'b0;
        u_ate.step(8);
        check("test_active", test_active, 1'b0);
        check("chain_oe", chain_oe, 1'b0);
    endtask : scn_reset
    // Single place that ends the run
    task automatic print_verdict();
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    // Hang guard, far above the expected run of about 2270 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        reset = 1'b1;
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
        u_ate.step(1);
        check("test_active", test_active, 1'b0);
        check("chain_oe", chain_oe, 1'b0);
        check("drive_oe", drive_oe, 1'b0);
        check("drive_even", drive_even, {`BT_EVEN_LEN{1'b1}});
        scn_bad_pattern();
        scn_nand();
        scn_drive();
        scn_exit();
        scn_reset();
        print_verdict();
    end
endmodule : board_test_mode_nand_tree_tb_top
